// >>> src/ext_irq_and_vector_select.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_and_vector_select (
  input wire logic clk,
  input wire logic resetn,
  input wire irq_vec_pkg::io_req_s io_req,
  input wire logic [2:0] ext_irq_pin,
  input wire logic status_i_flag,
  input wire logic [2:0] irq_taken,
  input wire logic instr_done,
  input wire logic exec_in_boot,
  input wire logic app_side_boot_lock,
  input wire logic boot_side_boot_lock,
  input wire logic [15:0] boot_section_base,
  input wire logic io_clk_run,
  input wire logic sleeping,
  input wire logic wdt_tick,
  output logic [7:0] io_rdata,
  output logic [2:0] irq_req,
  output logic irq_block,
  output logic [15:0] vec_base,
  output logic wake_req
);
  import irq_vec_pkg::*;

  // true when the access targets io offset off
  function automatic logic io_hit(input io_req_s r,
                                  input logic [5:0] off);
    logic [7:0] a;
    a = {2'h0, off};
    if (r.io_space) begin
      io_hit = (r.addr == a);
    end else begin
      io_hit = (r.addr == 8'(a + DATA_SPACE_OFS));
    end
  endfunction

  // register bit of pin i; enables and flags share one layout
  function automatic int pin_bit(input int i);
    case (i)
      PIN_A: pin_bit = EN_A_BIT;
      PIN_B: pin_bit = EN_B_BIT;
      default: pin_bit = EN_C_BIT;
    endcase
  endfunction

  // decoded strobes
  logic wr_mcu, wr_csr, wr_gic, wr_flg;
  logic rd_mcu, rd_csr, rd_gic, rd_flg;
  assign wr_mcu = io_req.wr & io_hit(io_req, OFS_MCU_CTRL);
  assign wr_csr = io_req.wr & io_hit(io_req, OFS_MCU_CSR);
  assign wr_gic = io_req.wr & io_hit(io_req, OFS_GEN_IRQ_CTRL);
  assign wr_flg = io_req.wr & io_hit(io_req, OFS_IRQ_FLAGS);
  assign rd_mcu = io_req.rd & io_hit(io_req, OFS_MCU_CTRL);
  assign rd_csr = io_req.rd & io_hit(io_req, OFS_MCU_CSR);
  assign rd_gic = io_req.rd & io_hit(io_req, OFS_GEN_IRQ_CTRL);
  assign rd_flg = io_req.rd & io_hit(io_req, OFS_IRQ_FLAGS);

  // register state
  logic [7:0] mcu_ctrl_q, mcu_ctrl_d; // whole byte kept
  logic sense_c_q, sense_c_d; // only live bit of status reg
  logic [2:0] en_q, en_d; // per pin enables
  logic [2:0] flag_q, flag_d; // sticky edge flags
  logic vsel_q, vsel_d; // vector table select
  logic [7:0] rdata_q, rdata_d;

  // vector change sequencer state
  vs_state_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;

  // outputs
  logic [2:0] req_q, req_d;
  logic block_q, block_d;
  logic [15:0] base_q, base_d;
  logic wake_q, wake_d;
  logic [1:0] lvl_cnt_q, lvl_cnt_d;

  // per pin sensing
  logic [1:0] mode [3];
  logic [2:0] evt, low_lvl, run;
  assign mode[PIN_A] = mcu_ctrl_q[SENSE_A_LO +: 2];
  assign mode[PIN_B] = mcu_ctrl_q[SENSE_B_LO +: 2];
  // third pin forced onto an edge code
  assign mode[PIN_C] = {1'b1, sense_c_q};
  // first two edge paths stop with the io clock
  assign run = {1'b1, io_clk_run, io_clk_run};

  // pin level is read whatever its direction
  generate
    for (genvar i = 0; i < 3; i++) begin : g_pin
      pin_sense u_sense (
        .clk(clk),
        .resetn(resetn),
        .pin(ext_irq_pin[i]),
        .edge_run(run[i]),
        .mode(mode[i]),
        .evt(evt[i]),
        .low_lvl(low_lvl[i])
      );
    end
  endgenerate

  logic [2:0] lvl_mode;
  assign lvl_mode = {1'b0, mode[PIN_B] == SENSE_LOW,
                     mode[PIN_A] == SENSE_LOW};

  // sense control registers
  always_comb begin
    mcu_ctrl_d = wr_mcu ? io_req.wdata : mcu_ctrl_q;
    sense_c_d = wr_csr ? io_req.wdata[SENSE_C_BIT] : sense_c_q;
  end

  // vector change sequence; enables take any write
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    vsel_d = vsel_q;
    en_d = en_q;
    if (wr_gic) begin
      for (int i = 0; i < 3; i++) begin
        en_d[i] = io_req.wdata[pin_bit(i)];
      end
    end
    case (st_q)
      VS_IDLE: begin
        if (wr_gic && io_req.wdata[VEC_CHG_BIT]) begin
          st_d = VS_ARMED;
          cnt_d = 3'h0;
        end
      end
      VS_ARMED: begin
        if (wr_gic && io_req.wdata[VEC_CHG_BIT]) begin
          // re-arming restarts the window
          cnt_d = 3'h0;
        end else if (wr_gic) begin
          vsel_d = io_req.wdata[VEC_SEL_BIT];
          st_d = VS_HOLD;
        end else if (cnt_q == 3'(CHG_WINDOW_CYC - 3'h1)) begin
          st_d = VS_IDLE;
        end else begin
          cnt_d = 3'(cnt_q + 3'h1);
        end
      end
      VS_HOLD: begin
        // instruction after the select write has retired
        if (instr_done) begin
          st_d = VS_IDLE;
        end
      end
      default: st_d = VS_IDLE;
    endcase
  end

  // flags: set beats both clears in the same cycle
  always_comb begin
    flag_d = flag_q;
    for (int i = 0; i < 3; i++) begin
      if (wr_flg && io_req.wdata[pin_bit(i)]) begin
        flag_d[i] = 1'b0;
      end
      if (irq_taken[i]) begin
        flag_d[i] = 1'b0;
      end
      if (evt[i]) begin
        flag_d[i] = 1'b1;
      end
      if (lvl_mode[i]) begin
        flag_d[i] = 1'b0;
      end
    end
  end

  // read mux, answer one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (rd_mcu) begin
      rdata_d = mcu_ctrl_q;
    end else if (rd_csr) begin
      rdata_d[SENSE_C_BIT] = sense_c_q;
    end else if (rd_gic) begin
      rdata_d[EN_B_BIT] = en_q[PIN_B];
      rdata_d[EN_A_BIT] = en_q[PIN_A];
      rdata_d[EN_C_BIT] = en_q[PIN_C];
      rdata_d[VEC_SEL_BIT] = vsel_q;
      rdata_d[VEC_CHG_BIT] = (st_q == VS_ARMED);
    end else if (rd_flg) begin
      // a level-mode flag reads zero even in its first cycle
      rdata_d[EN_B_BIT] = flag_q[PIN_B] & ~lvl_mode[PIN_B];
      rdata_d[EN_A_BIT] = flag_q[PIN_A] & ~lvl_mode[PIN_A];
      rdata_d[EN_C_BIT] = flag_q[PIN_C];
    end
  end

  // request gating; global flag only read, never changed
  logic lock_off;
  always_comb begin
    lock_off = (vsel_q & app_side_boot_lock & ~exec_in_boot) |
               (~vsel_q & boot_side_boot_lock & exec_in_boot);
    block_d = (st_d != VS_IDLE);
    req_d = 3'h0;
    for (int i = 0; i < 3; i++) begin
      req_d[i] = status_i_flag & en_q[i] & ~block_d & ~lock_off &
                 (flag_q[i] | (lvl_mode[i] & low_lvl[i]));
    end
    base_d = vsel_q ? boot_section_base : 16'h0000;
  end

  // wake: two watchdog samples qualify a low level
  logic any_low;
  always_comb begin
    any_low = |(en_q & lvl_mode & low_lvl);
    lvl_cnt_d = lvl_cnt_q;
    if (!any_low) begin
      lvl_cnt_d = 2'h0;
    end else if (wdt_tick && lvl_cnt_q != WAKE_SAMPLES) begin
      lvl_cnt_d = 2'(lvl_cnt_q + 2'h1);
    end
    wake_d = wake_q;
    if (!sleeping) begin
      wake_d = 1'b0;
    end
    // once qualified, wake stands even if level vanishes
    if (sleeping && (lvl_cnt_q == WAKE_SAMPLES ||
        |(en_q & ~lvl_mode & evt))) begin
      wake_d = 1'b1;
    end
  end

  // all registers of the block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mcu_ctrl_q <= RST_MCU_CTRL;
      sense_c_q <= 1'b0;
      en_q <= 3'h0;
      flag_q <= 3'h0;
      vsel_q <= RST_GEN_IRQ_CTRL[VEC_SEL_BIT];
      rdata_q <= 8'h00;
      st_q <= VS_IDLE;
      cnt_q <= 3'h0;
      req_q <= 3'h0;
      block_q <= 1'b0;
      base_q <= 16'h0000;
      wake_q <= 1'b0;
      lvl_cnt_q <= 2'h0;
    end else begin
      mcu_ctrl_q <= mcu_ctrl_d;
      sense_c_q <= sense_c_d;
      en_q <= en_d;
      flag_q <= flag_d;
      vsel_q <= vsel_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      block_q <= block_d;
      base_q <= base_d;
      wake_q <= wake_d;
      lvl_cnt_q <= lvl_cnt_d;
    end
  end

  assign io_rdata = rdata_q;
  assign irq_req = req_q;
  assign irq_block = block_q;
  assign vec_base = base_q;
  assign wake_req = wake_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic armed;
  assign armed = (st_q == VS_ARMED);

  sequence s_arm_quiet;
    $rose(armed) ##0 (!wr_gic)[*4];
  endsequence
  sequence s_sel_write;
    armed && wr_gic && !io_req.wdata[VEC_CHG_BIT];
  endsequence

  property p_vec_base;
    1'b1 |=> vec_base == ($past(vsel_q) ? $past(boot_section_base)
                                         : 16'h0000);
  endproperty
  a_vec_base: assert property (p_vec_base)
    else $error("vector base mismatch");

  property p_chg_timeout;
    s_arm_quiet |=> !armed && !block_q;
  endproperty
  a_chg_timeout: assert property (p_chg_timeout)
    else $error("change enable outlived four cycles");

  property p_sel_write;
    s_sel_write |=> !armed && vsel_q == $past(io_req.wdata[VEC_SEL_BIT]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write not applied");

  property p_sel_locked;
    !armed && wr_gic |=> vsel_q == $past(vsel_q);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("select changed without arming");

  property p_block_quiet;
    (st_q != VS_IDLE) |-> irq_req == 3'h0 && irq_block;
  endproperty
  a_block_quiet: assert property (p_block_quiet)
    else $error("request during vector change");

  property p_hold_ends;
    st_q == VS_HOLD && instr_done |=> st_q == VS_IDLE;
  endproperty
  a_hold_ends: assert property (p_hold_ends)
    else $error("block did not end after instruction");

  property p_gie_gate;
    irq_req[PIN_B] |-> $past(status_i_flag) && $past(en_q[PIN_B]);
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("second request without enables");

  property p_level_flag;
    rd_flg && lvl_mode[PIN_A] |=> !io_rdata[EN_A_BIT];
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("level mode flag read as one");

  property p_set_wins;
    evt[PIN_C] && wr_flg |=> flag_q[PIN_C];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag event lost to clear");

  property p_wake_two;
    sleeping && lvl_cnt_q == WAKE_SAMPLES |=> wake_req;
  endproperty
  a_wake_two: assert property (p_wake_two)
    else $error("qualified level did not wake");
endmodule
`default_nettype wire

// >>> src/irq_vec_pkg.sv
package irq_vec_pkg;
  // io offsets of the registers
  localparam logic [5:0] OFS_MCU_CTRL = 6'h35;
  localparam logic [5:0] OFS_MCU_CSR = 6'h34;
  localparam logic [5:0] OFS_GEN_IRQ_CTRL = 6'h3B;
  localparam logic [5:0] OFS_IRQ_FLAGS = 6'h3A;
  // data space sees the io map shifted up
  localparam logic [7:0] DATA_SPACE_OFS = 8'h20;
  // field positions
  localparam int SENSE_A_LO = 0;
  localparam int SENSE_B_LO = 2;
  localparam int SENSE_C_BIT = 6;
  localparam int EN_B_BIT = 7;
  localparam int EN_A_BIT = 6;
  localparam int EN_C_BIT = 5;
  localparam int VEC_SEL_BIT = 1;
  localparam int VEC_CHG_BIT = 0;
  // reset values
  localparam logic [7:0] RST_MCU_CTRL = 8'h00;
  localparam logic [7:0] RST_GEN_IRQ_CTRL = 8'h00;
  // sense encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // timing counts
  localparam logic [2:0] CHG_WINDOW_CYC = 3'h4;
  localparam logic [1:0] WAKE_SAMPLES = 2'h2;
  // pin indices
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  // vector change sequencer
  typedef enum logic [2:0] {
    VS_IDLE = 3'b001,
    VS_ARMED = 3'b010,
    VS_HOLD = 3'b100
  } vs_state_e;
  // one access from the core per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_s;
endpackage

// >>> src/pin_sense.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sense (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  input wire logic edge_run,
  input wire logic [1:0] mode,
  output logic evt,
  output logic low_lvl
);
  import irq_vec_pkg::*;
  logic [1:0] sync_q, sync_d; // stage 0 feeds stage 1 only
  logic prev_q, prev_d; // last sampled level
  logic act_q, act_d; // level after polarity
  logic s2;
  assign s2 = sync_q[1];
  // next values; prev and act frozen while the io clock is stopped, the synchroniser keeps sampling
  always_comb begin
    sync_d = {sync_q[0], pin};
    prev_d = edge_run ? s2 : prev_q;
    act_d = edge_run ? ((mode == SENSE_RISE) ? s2 : ~s2) : act_q;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 2'h3;
      prev_q <= 1'b1;
      act_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      act_q <= act_d;
    end
  end
  // edge, change or level decode
  always_comb begin
    evt = 1'b0;
    case (mode)
      SENSE_ANY: evt = edge_run & (s2 ^ prev_q);
      // polarity flip itself can fire, on purpose
      SENSE_FALL, SENSE_RISE: evt = edge_run & act_d & ~act_q;
      default: evt = 1'b0;
    endcase
    // level path ignores edge_run; modelled on clk here
    low_lvl = (mode == SENSE_LOW) & ~s2;
  end
endmodule
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the core: enters the routine of a pending request
module core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] irq_req,
  input wire logic ack_en,
  output logic [2:0] irq_taken
);
  // one entry pulse, then a one-cycle gap; a stale request still high after the gap is taken a second time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_taken <= 3'h0;
    end else begin
      irq_taken <= (ack_en && irq_taken == 3'h0) ? irq_req : 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ext_irq_and_vector_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_count++; $display("Error %s exp %h got %h", nm, ex, got); end end
module ext_irq_and_vector_select_tb_top;
  import irq_vec_pkg::*;
  // boot start as decoded from the size fuses
  localparam logic [15:0] BOOT_BASE = 16'h1c00;
  // a second decode, so the base is seen to follow the fuse input
  localparam logic [15:0] ALT_BASE = 16'h1e00;
  logic [15:0] boot_base;
  logic clk, resetn, stat_i, instr_done, in_boot, app_lock, boot_lock;
  logic io_run, sleeping, wdt_tick, ack_en, irq_block, wake_req;
  io_req_s io_req;
  logic [2:0] pin, irq_taken, irq_req;
  logic [7:0] io_rdata;
  logic [15:0] vec_base;
  int err_count, compares;

  ext_irq_and_vector_select ext_irq_and_vector_select_i (
    .clk(clk), .resetn(resetn), .io_req(io_req), .ext_irq_pin(pin),
    .status_i_flag(stat_i), .irq_taken(irq_taken),
    .instr_done(instr_done), .exec_in_boot(in_boot),
    .app_side_boot_lock(app_lock), .boot_side_boot_lock(boot_lock),
    .boot_section_base(boot_base), .io_clk_run(io_run),
    .sleeping(sleeping), .wdt_tick(wdt_tick), .io_rdata(io_rdata),
    .irq_req(irq_req), .irq_block(irq_block), .vec_base(vec_base),
    .wake_req(wake_req));
  core_model core_model_i (.clk(clk), .resetn(resetn), .irq_req(irq_req),
    .ack_en(ack_en), .irq_taken(irq_taken));

  // 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one access, strobe dropped after its edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic io);
    io_req = '{wr: w, rd: !w, io_space: io, addr: a, wdata: d};
    cyc(1);
    io_req = '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io);
    acc(1'b1, a, d, io);
    cyc(1);
  endtask

  // read data is valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] ex,
                    input string nm);
    acc(1'b0, a, 8'h00, io);
    `CHK(nm, ex, io_rdata)
    cyc(1);
  endtask

  task automatic tick();
    wdt_tick = 1'b1;
    cyc(1);
    wdt_tick = 1'b0;
    cyc(2);
  endtask

  // set sense of one input, then drop any flag the change raised
  task automatic sense(input int p, input int m);
    if (p == 2) begin
      wr(8'h34, {1'b0, m[0], 6'h00}, 1'b1);
    end else begin
      wr(8'h35, 8'(m << (2 * p)), 1'b1);
    end
    cyc(3);
    wr(8'h3a, 8'he0, 1'b1);
  endtask

  // move one pin, then check flag and request against the mode
  task automatic edge_chk(input int p, input int m, input logic lvl);
    logic ex;
    logic [7:0] fbit;
    fbit = 8'h01 << ((p == 0) ? 6 : (p == 1) ? 7 : 5);
    ex = (m == 1) || (m == 2 && !lvl) || (m == 3 && lvl);
    pin[p] = lvl;
    cyc(6);
    rd(8'h3a, 1'b1, ex ? fbit : 8'h00, "flag");
    `CHK("req", ex || (m == 0 && !lvl), irq_req[p])
    wr(8'h3a, 8'he0, 1'b1);
  endtask

  task automatic give_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #50000;
    err_count++;
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    io_req = '0;
    pin = 3'h7;
    stat_i = 1'b1;
    {instr_done, in_boot, app_lock, boot_lock} = 4'h0;
    {sleeping, wdt_tick, ack_en} = 3'h0;
    io_run = 1'b1;
    boot_base = BOOT_BASE;
    cyc(2);
    resetn = 1'b1;
    `CHK("vec_rst", 16'h0000, vec_base)
    rd(8'h35, 1'b1, 8'h00, "mcu_rst");
    rd(8'h5b, 1'b0, 8'h00, "gic_rst");
    wr(8'h55, 8'ha5, 1'b0);
    rd(8'h35, 1'b1, 8'ha5, "mcu_rw");
    rd(8'h10, 1'b1, 8'h00, "unmapped");
    // select write without arming is ignored
    wr(8'h3b, 8'h02, 1'b1);
    rd(8'h3b, 1'b1, 8'h00, "sel_unarmed");
    wr(8'h3b, 8'h01, 1'b1);
    `CHK("block_arm", 1'b1, irq_block)
    wr(8'h3b, 8'h02, 1'b1);
    cyc(1);
    `CHK("vec_boot", BOOT_BASE, vec_base)
    `CHK("block_hold", 1'b1, irq_block)
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    cyc(2);
    `CHK("block_end", 1'b0, irq_block)
    rd(8'h3b, 1'b1, 8'h02, "arm_clr");
    // arm left unused runs out
    wr(8'h3b, 8'h01, 1'b1);
    cyc(5);
    `CHK("block_out", 1'b0, irq_block)
    rd(8'h3b, 1'b1, 8'h02, "arm_out");
    wr(8'h3b, 8'h00, 1'b1);
    `CHK("vec_kept", BOOT_BASE, vec_base)
    boot_base = ALT_BASE;
    cyc(2);
    `CHK("vec_fuse", ALT_BASE, vec_base)
    wr(8'h3b, 8'h01, 1'b1);
    wr(8'h3b, 8'h00, 1'b1);
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    cyc(2);
    `CHK("vec_app", 16'h0000, vec_base)
    // every sense code on the first two inputs, both edge codes on the third
    wr(8'h3b, 8'he0, 1'b1);
    for (int p = 0; p < 3; p++) begin
      for (int m = (p == 2) ? 2 : 0; m < 4; m++) begin
        sense(p, m);
        edge_chk(p, m, 1'b0);
        edge_chk(p, m, 1'b1);
      end
    end
    // flag without enable, then gating and entry
    wr(8'h3b, 8'h00, 1'b1);
    wr(8'h35, 8'h08, 1'b1);
    pin[1] = 1'b0;
    cyc(6);
    rd(8'h3a, 1'b1, 8'h80, "flag_masked");
    `CHK("req_masked", 3'h0, irq_req)
    stat_i = 1'b0;
    wr(8'h3b, 8'h80, 1'b1);
    cyc(1);
    `CHK("req_noglobal", 3'h0, irq_req)
    stat_i = 1'b1;
    cyc(2);
    `CHK("req_b", 3'h2, irq_req)
    boot_lock = 1'b1;
    in_boot = 1'b1;
    cyc(2);
    `CHK("req_locked", 3'h0, irq_req)
    boot_lock = 1'b0;
    in_boot = 1'b0;
    ack_en = 1'b1;
    cyc(4);
    rd(8'h3a, 1'b1, 8'h00, "flag_taken");
    ack_en = 1'b0;
    pin[1] = 1'b1;
    // io clock stopped: only the third input still sees edges
    wr(8'h3b, 8'h60, 1'b1);
    wr(8'h35, 8'h02, 1'b1);
    sense(2, 2);
    io_run = 1'b0;
    pin = 3'h2;
    cyc(6);
    rd(8'h3a, 1'b1, 8'h20, "flag_stop");
    pin = 3'h7;
    cyc(6);
    io_run = 1'b1;
    cyc(4);
    wr(8'h3a, 8'he0, 1'b1);
    // level wake needs two watchdog samples
    wr(8'h35, 8'h00, 1'b1);
    sleeping = 1'b1;
    pin[0] = 1'b0;
    cyc(4);
    tick();
    `CHK("wake_one", 1'b0, wake_req)
    tick();
    `CHK("wake_two", 1'b1, wake_req)
    // level gone before start-up ends: wake stays, no request
    pin[0] = 1'b1;
    cyc(4);
    `CHK("wake_kept", 1'b1, wake_req)
    `CHK("lvl_gone", 1'b0, irq_req[0])
    sleeping = 1'b0;
    cyc(2);
    `CHK("wake_clr", 1'b0, wake_req)
    give_verdict();
  end
endmodule
`default_nettype wire
